/* eqg_gain_latch.v */
`timescale 1ns/1ps
`include "eqg_map.vh"
// Function
// - A transfer is 20 bits: 8 address bits then 12 setting bits.
// - Setting bits are shifted in only while chip select is high.
// - Falling chip select copies received setting into the gain latches.
// - Respond only to address 8C with strap high, 8D with strap low.
// - Each gain code step changes the band response by 2 dB.
// - Each band has 13 gain codes, from 12 dB cut to 12 dB boost.
// - Seven independent band gains for left and seven for right.
// - Updating one channel leaves the other channel's latched gains untouched.
// - Gains hold the flat code 6 from reset until the first latch; a valid flag shows that.
module eqg_gain_latch (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  // Serial link pins
  input  wire        serial_shift_clock,
  input  wire        serial_data_in,
  input  wire        chip_select,
  // Address strap pin
  input  wire        address_strap,
  // Band gain codes, band n at bits 4n+3:4n
  output reg  [27:0] left_band_gain,
  output reg  [27:0] right_band_gain,
  // Status
  output reg         settings_valid,
  output reg         settings_updated,
  output reg         frame_ignored
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and edge detection

  wire [3:0] pin_sync;
  reg        sclk_prev;
  reg        cs_prev;

  eqg_sync #(.WIDTH(4)) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .async_in ({address_strap, chip_select, serial_data_in, serial_shift_clock}),
    .sync_out (pin_sync)
  );

  wire sclk_s   = pin_sync[0];
  wire sdata_s  = pin_sync[1];
  wire cs_s     = pin_sync[2];
  wire strap_s  = pin_sync[3];

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_prev <= 1'b0;
      cs_prev   <= 1'b0;
    end else begin
      sclk_prev <= sclk_s;
      cs_prev   <= cs_s;
    end
  end

  // Edges seen two to three core cycles late; fine at a 5 MHz link
  wire sclk_rise = sclk_s & ~sclk_prev;
  wire cs_rise   = cs_s & ~cs_prev;
  wire cs_fall   = ~cs_s & cs_prev;

  wire [7:0] own_addr = strap_s ? `EQG_ADDR_STRAP_HIGH : `EQG_ADDR_STRAP_LOW;

  ////////////////////////////////////////////////////////////////////////////
  // Frame receiver

  localparam [1:0] ST_ADDR = 2'd0;
  localparam [1:0] ST_DATA = 2'd1;
  localparam [1:0] ST_SKIP = 2'd2;

  reg [1:0]  state;
  reg [1:0]  next_state;
  reg [7:0]  addr_shift;
  reg [3:0]  addr_cnt;
  reg [11:0] data_shift;
  reg [3:0]  data_cnt;

  wire addr_ok = (addr_cnt == `EQG_ADDR_BITS) && (addr_shift == own_addr);

  always @* begin
    next_state = state;
    case (state)
      ST_ADDR: begin
        if (cs_rise) begin
          next_state = addr_ok ? ST_DATA : ST_SKIP;
        end
      end
      ST_DATA: begin
        if (cs_fall) begin
          next_state = ST_ADDR;
        end
      end
      ST_SKIP: begin
        if (cs_fall) begin
          next_state = ST_ADDR;
        end
      end
      default: next_state = ST_ADDR;
    endcase
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state      <= ST_ADDR;
      addr_shift <= 8'h00;
      addr_cnt   <= 4'h0;
      data_shift <= 12'h000;
      data_cnt   <= 4'h0;
    end else begin
      state <= next_state;
      if (state == ST_ADDR) begin
        if (cs_rise) begin
          addr_cnt <= 4'h0;
          data_cnt <= 4'h0;
        end else if (sclk_rise && !cs_s) begin
          // LSB first: new bit enters at the top
          addr_shift <= {sdata_s, addr_shift[7:1]};
          if (addr_cnt != `EQG_ADDR_BITS) begin
            addr_cnt <= addr_cnt + 4'h1;
          end
        end
      end else if (state == ST_DATA && cs_s && sclk_rise) begin
        data_shift <= {sdata_s, data_shift[11:1]};
        if (data_cnt != `EQG_DATA_CNT_MAX) begin
          data_cnt <= data_cnt + 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Setting decode and latches

  // A word is accepted only with a legal band and a code inside the 13 steps
  function word_legal;
    input [11:0] word;
    begin
      word_legal = (word[`EQG_FLD_BAND_MSB:`EQG_FLD_BAND_LSB] < 3'd7) &&
                   (word[`EQG_FLD_CODE_MSB:`EQG_FLD_CODE_LSB] <= `EQG_GAIN_CODE_MAX);
    end
  endfunction

  // Decode of the target band, shared by both channels
  function hits_band;
    input [11:0] word;
    input [2:0]  band;
    begin
      hits_band = (word[`EQG_FLD_BAND_MSB:`EQG_FLD_BAND_LSB] == band);
    end
  endfunction

  // Short frames or surplus setting bits are discarded rather than guessed at
  wire latch_now = cs_fall && (state == ST_DATA) && (data_cnt == `EQG_DATA_BITS) &&
                   word_legal(data_shift);
  wire to_right  = data_shift[`EQG_FLD_CHAN_BIT];
  wire [3:0] new_code = data_shift[`EQG_FLD_CODE_MSB:`EQG_FLD_CODE_LSB];

  genvar b;
  generate
    for (b = 0; b < `EQG_BANDS; b = b + 1) begin : g_band
      localparam [31:0] BAND_IDX = b;
      always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          left_band_gain[4*b+3:4*b]  <= `EQG_GAIN_FLAT;
          right_band_gain[4*b+3:4*b] <= `EQG_GAIN_FLAT;
        end else if (latch_now && hits_band(data_shift, BAND_IDX[2:0])) begin
          // Only the addressed channel's latch moves
          if (to_right) begin
            right_band_gain[4*b+3:4*b] <= new_code;
          end else begin
            left_band_gain[4*b+3:4*b]  <= new_code;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Status

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      settings_valid   <= 1'b0;
      settings_updated <= 1'b0;
      frame_ignored    <= 1'b0;
    end else begin
      // Reset value of the gains is not meaningful until this rises
      if (latch_now) begin
        settings_valid <= 1'b1;
      end
      settings_updated <= latch_now;
      frame_ignored    <= cs_fall && (state != ST_ADDR) && !latch_now;
    end
  end

endmodule // eqg_gain_latch

/* eqg_gain_latch_assertions.sv */
`timescale 1ns/1ps
module eqg_gain_latch_assertions (
  // Clock and reset
  input wire        core_clk,
  input wire        rstn,
  // Link select and results
  input wire        chip_select,
  input wire [27:0] left_band_gain,
  input wire [27:0] right_band_gain,
  input wire        settings_valid,
  input wire        settings_updated,
  input wire        frame_ignored
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence sel_fall;
    chip_select ##1 !chip_select;
  endsequence
  // Pin is seen through a synchroniser, so the answer comes some cycles late
  a_frame_answer: assert property (sel_fall |-> ##[1:7] (settings_updated || frame_ignored))
    else $error("select fall unanswered");
  a_gain_quiet: assert property (($changed(left_band_gain) || $changed(right_band_gain))
    |-> !$past(chip_select) && !$past(chip_select, 2))
    else $error("gain moved in frame");
  a_chan_indep: assert property ($changed(left_band_gain) |-> $stable(right_band_gain))
    else $error("both channels moved");
  a_valid_sticky: assert property (settings_valid |=> settings_valid)
    else $error("valid dropped");
  a_upd_valid: assert property (settings_updated |-> settings_valid)
    else $error("update without valid");
  a_upd_pulse: assert property (settings_updated |=> !settings_updated)
    else $error("update pulse too long");
  a_no_both: assert property (!(settings_updated && frame_ignored))
    else $error("update and ignore");
  // Gains would move on the same edge that raises the ignore pulse, so look two cycles back
  a_ign_keeps: assert property (frame_ignored |-> left_band_gain == $past(left_band_gain, 2)
    && right_band_gain == $past(right_band_gain, 2))
    else $error("ignored frame moved gains");
endmodule // eqg_gain_latch_assertions
bind eqg_gain_latch eqg_gain_latch_assertions chk_u (.core_clk(core_clk), .rstn(rstn), .chip_select(chip_select),
  .left_band_gain(left_band_gain), .right_band_gain(right_band_gain), .settings_valid(settings_valid),
  .settings_updated(settings_updated), .frame_ignored(frame_ignored));

/* eqg_link_model.sv */
`timescale 1ns/1ps
module eqg_link_model (
  // Clock
  input  wire core_clk,
  // Link pins
  output reg  serial_shift_clock = 1'b0,
  output reg  serial_data_in = 1'b0,
  output reg  chip_select = 1'b0
);
  // Four core cycles per level gives the 200 ns link period
  task automatic wt;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic bit_out(input logic b);
    serial_data_in <= b;
    wt;
    serial_shift_clock <= 1'b1;
    wt;
    serial_shift_clock <= 1'b0;
  endtask
  task automatic send(input logic [7:0] a, input int n, input logic [11:0] w);
    for (int i = 0; i < 8; i++) bit_out(a[i]);
    wt;
    chip_select <= 1'b1;
    for (int i = 0; i < n; i++) bit_out(w[i]);
    wt;
    chip_select <= 1'b0;
    // Released data line must not keep showing the last bit
    serial_data_in <= ~serial_data_in;
  endtask
endmodule // eqg_link_model

/* eqg_map.vh */
`ifndef EQG_MAP_VH
`define EQG_MAP_VH

// Frame layout
`define EQG_FRAME_BITS      5'd20
`define EQG_ADDR_BITS       4'd8
`define EQG_DATA_BITS       4'd12
`define EQG_DATA_CNT_MAX    4'd13

// Device addresses picked by the strap
`define EQG_ADDR_STRAP_HIGH 8'h8c
`define EQG_ADDR_STRAP_LOW  8'h8d

// Setting word fields
`define EQG_FLD_CODE_LSB    0
`define EQG_FLD_CODE_MSB    3
`define EQG_FLD_BAND_LSB    4
`define EQG_FLD_BAND_MSB    6
`define EQG_FLD_CHAN_BIT    7

// Gain codes: code 0 is full cut, each step is one gain increment
`define EQG_GAIN_STEP_DB    2
`define EQG_GAIN_CODE_MAX   4'hc
`define EQG_GAIN_FLAT       4'h6
`define EQG_GAIN_RESET      28'h6666666
`define EQG_BANDS           7
`define EQG_CODE_W          4

`endif

/* eqg_sync.v */
`timescale 1ns/1ps
module eqg_sync #(
  parameter WIDTH = 4
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             rstn,
  // Asynchronous levels in, synchronised levels out
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta;
      reg stable;
      // First stage feeds only the second stage
      always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          meta   <= 1'b0;
          stable <= 1'b0;
        end else begin
          meta   <= async_in[i];
          stable <= meta;
        end
      end
      assign sync_out[i] = stable;
    end
  endgenerate

endmodule // eqg_sync

/* test_serial_equalizer_gain_latch.sv */
`timescale 1ns/1ps
`include "eqg_map.vh"
module test_serial_equalizer_gain_latch;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        address_strap = 1'b1;
  wire         serial_shift_clock, serial_data_in, chip_select, valid, upd, ign;
  wire  [27:0] gl, gr;
  logic [27:0] el = `EQG_GAIN_RESET;
  logic [27:0] er = `EQG_GAIN_RESET;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          nu = 0;
  int          ni = 0;
  always #12.5 core_clk = ~core_clk;
  eqg_link_model lk (.core_clk(core_clk), .serial_shift_clock(serial_shift_clock),
    .serial_data_in(serial_data_in), .chip_select(chip_select));
  eqg_gain_latch dut_u (.core_clk(core_clk), .rstn(rstn), .serial_shift_clock(serial_shift_clock),
    .serial_data_in(serial_data_in), .chip_select(chip_select), .address_strap(address_strap),
    .left_band_gain(gl), .right_band_gain(gr), .settings_valid(valid), .settings_updated(upd), .frame_ignored(ign));
  task automatic finish_test;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    nu += upd;
    ni += ign;
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      finish_test;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic ok_of(input logic [7:0] a, input int n, input logic [11:0] w);
    return a == (address_strap ? `EQG_ADDR_STRAP_HIGH : `EQG_ADDR_STRAP_LOW) && n == 12
      && w[6:4] != 3'd7 && w[3:0] <= `EQG_GAIN_CODE_MAX;
  endfunction
  task automatic frame(input logic [7:0] a, input int n, input logic [11:0] w);
    int   u;
    int   i;
    logic ok;
    u = nu;
    i = ni;
    ok = ok_of(a, n, w);
    lk.send(a, n, w);
    repeat (12) @(posedge core_clk);
    if (ok && w[7]) er[4*w[6:4] +: 4] = w[3:0];
    if (ok && !w[7]) el[4*w[6:4] +: 4] = w[3:0];
    chk(nu - u, ok);
    chk(ni - i, !ok);
    chk(gl, el);
    chk(gr, er);
  endtask
  initial begin
    void'($urandom(85));
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(valid, 0);
    frame(8'h8c, 12, 12'h06c);
    frame(8'h8c, 12, 12'h080);
    frame(8'h8d, 12, 12'h011);
    frame(8'h8c, 12, 12'h00d);
    frame(8'h8c, 12, 12'h070);
    frame(8'h8c, 11, 12'h013);
    chk(valid, 1);
    repeat (40) begin
      address_strap <= $urandom;
      @(posedge core_clk);
      frame($urandom % 4 ? 8'h8c | ($urandom % 2) : $urandom, $urandom % 6 ? 12 : 11, $urandom);
    end
    finish_test;
  end
endmodule // test_serial_equalizer_gain_latch
